/* design/bus_tenure_arbitration.sv */
// Requester-side bus tenure, transfer termination and reset fetch logic
// What this block does
// R1 - Ignore option off: sample ack, inhibits and data at end of second clock
// R2 - Ack seen: end transfer and hand captured data to the core
// R3 - No ack: drop data, insert wait states, resample every rising bus clock edge
// R4 - Ignore option on: raise early sample flag during second clock
// R5 - Grant too slow: withdraw bus request, then request again
// R6 - Arbiter treats bus request as status only; it may reassert at once
// R7 - Tenure starts at our first start strobe after grant
// R8 - Started tenure ends by tenure-end pulse or busy line rising
// R9 - Granted but never strobed: no tenure end is signalled
// R10 - Arbiter holds start strobe negated in reset and grants one master
// R11 - After reset start only if strobe unseen, else await tenure end
// R12 - Granted and bus free: begin the cycle the following clock
// R13 - Releasing master drives busy and tenure end inactive before float
// R14 - Negate request when last needed cycle starts with nothing pending
// R15 - Release: busy off, float bus, tenure end one clock, high one clock
// R16 - Busy line driven high one core clock only before floating
// R17 - Interrupt acknowledge drives level on transfer modifier outputs
// R18 - Autovector request selects internal vector 25 to 31 by level
// R19 - Bus error on acknowledge gives spurious vector 24
// R20 - After reset read long words at 0 and 4 into stack pointer and PC
// R21 - Reset pin overrides everything and aborts work in progress
`timescale 1ns/1ps
module bus_tenure_arbitration
  import bus_tenure_pkg::*;
#(
  parameter int GRANT_WAIT_CYC = GRANT_WAIT
) (
  // Clocks and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              bus_clk,
  // Core request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              req_iack,
  input  wire logic [TM_W-1:0]   req_level,
  input  wire logic              req_more,
  input  wire logic              ignore_state_en,
  // Core response
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_err,
  output logic [VEC_W-1:0]       rsp_vector,
  output logic                   rsp_burst_inh,
  output logic                   rsp_cache_inh,
  output logic                   boot_done,
  output logic [DATA_W-1:0]      boot_sp,
  output logic [DATA_W-1:0]      boot_pc,
  // Arbitration pins
  input  wire logic              reset_input_pin_n,
  output logic                   bus_request_out_n,
  input  wire logic              bus_grant_in_n,
  input  wire logic              transfer_start_strobe_in_n,
  output logic                   transfer_start_strobe_out_n,
  output logic                   transfer_start_strobe_oe_n,
  input  wire logic              bus_busy_line_in_n,
  output logic                   bus_busy_line_out_n,
  output logic                   bus_busy_line_oe_n,
  input  wire logic              tenure_end_toggle_in_n,
  output logic                   tenure_end_toggle_out_n,
  output logic                   tenure_end_toggle_oe_n,
  // Transfer pins
  input  wire logic              transfer_ack_n,
  input  wire logic              transfer_err_n,
  input  wire logic              burst_inhibit_in_n,
  input  wire logic              cache_inhibit_in_n,
  input  wire logic              auto_vector_req_n,
  output logic                   early_sample_flag,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe_n,
  output logic                   rw_out,
  output logic [TM_W-1:0]        tm_out,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n
);

  localparam int GW_W = $clog2(GRANT_WAIT_CYC + 1);
  localparam logic [GW_W-1:0] GW_LAST = GW_W'(GRANT_WAIT_CYC - 1);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic              req_tgl;
    logic              busy;
    logic              rsp_seen;
    logic              cur_write;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] cur_wdata;
    logic              cur_iack;
    logic [TM_W-1:0]   cur_level;
    logic              cur_more;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic              rsp_err;
    logic [VEC_W-1:0]  rsp_vec;
    logic              rsp_bi;
    logic              rsp_ci;
    logic              own_prev;
    logic              boot_done;
    logic [DATA_W-1:0] sp;
    logic [DATA_W-1:0] pc;
  } core_t;

  typedef struct packed {
    link_state_t       st;
    logic              c2;
    logic [GW_W-1:0]   gwait;
    logic              other_ten;
    logic              own;
    logic              bb_prev;
    logic              req_seen;
    logic              pending;
    logic [1:0]        boot;
    logic              boot_done;
    logic              is_boot;
    logic              cur_write;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] cur_wdata;
    logic              cur_iack;
    logic [TM_W-1:0]   cur_level;
    logic [TM_W-1:0]   cur_tm;
    logic              cur_more;
    logic              rsp_tgl;
    logic [DATA_W-1:0] rsp_data;
    logic              rsp_err;
    logic [VEC_W-1:0]  rsp_vec;
    logic              rsp_bi;
    logic              rsp_ci;
    logic [DATA_W-1:0] reset_sp;
    logic [DATA_W-1:0] reset_pc;
  } link_t;

  core_t r;
  core_t next_r;
  link_t l;
  link_t next_l;

  // ****************************************************************
  // Crossings
  // ****************************************************************
  logic [3:0] core_sync;
  logic [2:0] link_sync;
  logic       core_rst_pin;
  logic       link_rst_pin;
  logic       ign_s;

  two_flop_sync #(.WIDTH(4)) u_core_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({reset_input_pin_n, l.rsp_tgl, l.own, l.boot_done}),
    .q     (core_sync)
  );

  two_flop_sync #(.WIDTH(3)) u_link_sync (
    .clk   (bus_clk),
    .rst_n (rst_n),
    .d     ({reset_input_pin_n, r.req_tgl, ignore_state_en}),
    .q     (link_sync)
  );

  // Synchroniser resets low, so the pin reads asserted until it settles
  assign core_rst_pin = !core_sync[3];
  assign link_rst_pin = !link_sync[2];
  assign ign_s        = link_sync[0];

  // ****************************************************************
  // Core side
  // ****************************************************************
  logic bb_release;

  // Busy is negated for one core clock only, then floated
  assign bb_release = r.own_prev && !core_sync[1]; // see R16

  always_comb begin
    next_r           = r;
    next_r.rsp_valid = 1'b0;
    next_r.own_prev  = core_sync[1];
    next_r.boot_done = core_sync[0];
    if (core_sync[0] && !r.boot_done) begin
      next_r.sp = l.reset_sp; // see R20
      next_r.pc = l.reset_pc;
    end
    if (req_valid && req_ready) begin
      next_r.req_tgl   = !r.req_tgl;
      next_r.busy      = 1'b1;
      next_r.cur_write = req_write;
      next_r.cur_addr  = req_addr;
      next_r.cur_wdata = req_wdata;
      next_r.cur_iack  = req_iack;
      next_r.cur_level = req_level;
      next_r.cur_more  = req_more;
    end
    if (core_sync[2] != r.rsp_seen) begin
      next_r.rsp_seen = core_sync[2];
      if (r.busy) begin
        next_r.busy      = 1'b0; // see R2
        next_r.rsp_valid = 1'b1;
        next_r.rsp_data  = l.rsp_data;
        next_r.rsp_err   = l.rsp_err;
        next_r.rsp_vec   = l.rsp_vec;
        next_r.rsp_bi    = l.rsp_bi;
        next_r.rsp_ci    = l.rsp_ci;
      end
    end
    if (core_rst_pin) begin
      next_r.busy      = 1'b0; // see R21
      next_r.rsp_valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign req_ready           = !r.busy && r.boot_done && !core_rst_pin;
  assign rsp_valid           = r.rsp_valid;
  assign rsp_data            = r.rsp_data;
  assign rsp_err             = r.rsp_err;
  assign rsp_vector          = r.rsp_vec;
  assign rsp_burst_inh       = r.rsp_bi;
  assign rsp_cache_inh       = r.rsp_ci;
  assign boot_done           = r.boot_done;
  assign boot_sp             = r.sp;
  assign boot_pc             = r.pc;
  assign bus_busy_line_out_n = !core_sync[1];
  assign bus_busy_line_oe_n  = !(core_sync[1] || bb_release);

  // ****************************************************************
  // Link side
  // ****************************************************************
  logic want;
  logic can_start;

  assign want      = !l.boot_done || l.pending;
  // Unseen start strobe from others plus grant and free bus
  assign can_start = !bus_grant_in_n && !l.other_ten && bus_busy_line_in_n; // see R11

  always_comb begin
    next_l         = l;
    next_l.bb_prev = bus_busy_line_in_n;
    if (link_sync[1] != l.req_seen) begin
      next_l.req_seen = link_sync[1];
      next_l.pending  = 1'b1;
    end
    // Relies on the old owner driving the lines high before floating
    if (!tenure_end_toggle_in_n || (!l.bb_prev && bus_busy_line_in_n)) begin
      next_l.other_ten = 1'b0; // see R8, R13
    end
    // A start strobe that is not ours opens a foreign tenure; set wins
    if (!transfer_start_strobe_in_n && !l.own) begin
      next_l.other_ten = 1'b1; // see R7, R11
    end
    case (l.st)
      L_RST: begin
        if (!link_rst_pin) begin
          next_l.st = L_IDLE;
        end
      end
      L_IDLE: begin
        if (want) begin
          next_l.st    = L_REQ;
          next_l.gwait = '0;
        end
      end
      L_REQ: begin
        if (can_start) begin
          next_l.st  = L_ADDR; // see R12
          next_l.own = 1'b1;
        end else if (l.gwait == GW_LAST) begin
          next_l.st = L_DROP; // see R5
        end else begin
          next_l.gwait = l.gwait + 1'b1;
        end
      end
      L_DROP: begin
        next_l.st = L_IDLE; // see R6
      end
      L_ADDR: begin
        next_l.st = L_DATA;
        next_l.c2 = 1'b1;
      end
      L_DATA: begin
        next_l.c2 = 1'b0;
        // Without ack or error the data bus is ignored and we wait
        if (!transfer_ack_n || !transfer_err_n) begin // see R1, R3
          next_l.st     = L_PARK;
          next_l.rsp_bi = !burst_inhibit_in_n;
          next_l.rsp_ci = !cache_inhibit_in_n;
          if (l.is_boot) begin
            // A failed reset fetch is simply retried
            if (transfer_err_n) begin // see R20
              if (l.boot == 2'h0) begin
                next_l.reset_sp = data_in;
              end else begin
                next_l.reset_pc = data_in;
              end
              next_l.boot      = l.boot + 2'h1;
              next_l.boot_done = (l.boot + 2'h1) == BOOT_READS;
            end
          end else begin
            next_l.rsp_tgl  = !l.rsp_tgl; // see R2
            next_l.rsp_data = data_in;
            next_l.rsp_err  = !transfer_err_n && !l.cur_iack;
            next_l.rsp_vec  = '0;
            if (l.cur_iack) begin
              if (!transfer_err_n) begin
                next_l.rsp_vec = VEC_SPURIOUS; // see R19
              end else if (!auto_vector_req_n) begin
                next_l.rsp_vec = VEC_AUTO_BASE + {5'h00, l.cur_level}; // see R18
              end else begin
                next_l.rsp_vec = data_in[VEC_W-1:0];
              end
            end
          end
        end
      end
      L_PARK: begin
        if (bus_grant_in_n) begin
          next_l.st  = L_TEND; // see R15
          next_l.own = 1'b0;
        end else if (want) begin
          next_l.st = L_ADDR;
        end
      end
      L_TEND: begin
        next_l.st = L_TNEG;
      end
      L_TNEG: begin
        next_l.st = L_IDLE;
      end
      default: begin
        next_l.st = L_RST;
      end
    endcase
    // Latch the next access as its address phase begins
    if (next_l.st == L_ADDR) begin
      next_l.is_boot = !l.boot_done;
      if (!l.boot_done) begin
        next_l.cur_addr  = (l.boot == 2'h0) ? BOOT_SP_ADDR : BOOT_PC_ADDR; // see R20
        next_l.cur_write = 1'b0;
        next_l.cur_iack  = 1'b0;
        next_l.cur_tm    = TM_NORMAL;
        next_l.cur_more  = (l.boot == 2'h0);
      end else begin
        next_l.pending   = 1'b0;
        next_l.cur_addr  = r.cur_addr;
        next_l.cur_write = r.cur_write;
        next_l.cur_wdata = r.cur_wdata;
        next_l.cur_iack  = r.cur_iack;
        next_l.cur_level = r.cur_level;
        next_l.cur_tm    = r.cur_iack ? r.cur_level : TM_NORMAL; // see R17
        next_l.cur_more  = r.cur_more;
      end
    end
    if (link_rst_pin) begin
      next_l.st        = L_RST; // see R21
      next_l.own       = 1'b0;
      next_l.pending   = 1'b0;
      next_l.req_seen  = link_sync[1];
      next_l.boot      = 2'h0;
      next_l.boot_done = 1'b0;
    end
  end

  always_ff @(posedge bus_clk or negedge rst_n) begin
    if (!rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Request stays up only while more cycles are owed
  assign bus_request_out_n = !((l.st == L_REQ) || // see R14
                               (((l.st == L_ADDR) || (l.st == L_DATA)) && l.cur_more) ||
                               ((l.st == L_PARK) && want));
  assign transfer_start_strobe_out_n = (l.st != L_ADDR);
  assign transfer_start_strobe_oe_n  = !l.own;
  // No tenure end pulse unless a tenure was opened
  assign tenure_end_toggle_out_n = (l.st != L_TEND); // see R9, R15
  assign tenure_end_toggle_oe_n  = !((l.st == L_TEND) || (l.st == L_TNEG));
  assign early_sample_flag = (l.st == L_DATA) && l.c2 && ign_s; // see R4
  assign addr_out  = l.cur_addr;
  assign addr_oe_n = !l.own;
  assign rw_out    = !l.cur_write;
  assign tm_out    = l.cur_tm;
  assign data_out  = l.cur_wdata;
  assign data_oe_n = !(l.cur_write && ((l.st == L_ADDR) || (l.st == L_DATA)));

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_tend_pulse;
    !tenure_end_toggle_out_n && !tenure_end_toggle_oe_n ##1
    tenure_end_toggle_out_n && !tenure_end_toggle_oe_n ##1 tenure_end_toggle_oe_n;
  endsequence

  sequence s_bb_release;
    bus_busy_line_out_n && !bus_busy_line_oe_n ##1 bus_busy_line_oe_n;
  endsequence

  a_ack_ends_xfer: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R2
    (l.st == L_DATA && !transfer_ack_n && !link_rst_pin) |=> l.st == L_PARK)
    else $error("ack did not end transfer");
  a_wait_holds: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R3
    (l.st == L_DATA && transfer_ack_n && transfer_err_n && !link_rst_pin)
    |=> l.st == L_DATA && !early_sample_flag)
    else $error("wait state not inserted");
  a_early_flag: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R4
    (l.st == L_ADDR && !link_rst_pin) |=> early_sample_flag == $past(ign_s))
    else $error("early sample flag wrong in second clock");
  a_grant_drop: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R5
    (l.st == L_DROP) |-> bus_request_out_n && $past(l.gwait) == GW_LAST)
    else $error("request dropped at wrong time");
  a_tenure_end: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R15
    ($fell(l.own) && !$past(link_rst_pin)) |-> s_tend_pulse)
    else $error("tenure end pulse malformed");
  a_no_stray_end: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R9
    (l.st == L_TEND) |-> $past(l.own) && !l.own)
    else $error("tenure end without tenure");
  a_prompt_start: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R12
    (l.st == L_REQ && can_start && !link_rst_pin)
    |=> (!transfer_start_strobe_out_n && !transfer_start_strobe_oe_n)
    ##1 transfer_start_strobe_out_n)
    else $error("cycle not begun after grant");
  a_boot_addr: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R20
    (l.st == L_ADDR && l.is_boot) |-> addr_out == (l.cur_more ? BOOT_SP_ADDR : BOOT_PC_ADDR))
    else $error("reset fetch address wrong");
  a_spurious_vec: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R19
    (l.st == L_DATA && l.cur_iack && !l.is_boot && !transfer_err_n && !link_rst_pin)
    |=> l.rsp_vec == VEC_SPURIOUS)
    else $error("spurious vector not used");
  a_reset_abort: assert property (@(posedge bus_clk) disable iff (!rst_n) // see R21
    link_rst_pin |=> l.st == L_RST && !l.own)
    else $error("reset pin did not abort");
  a_busy_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R16
    $fell(core_sync[1]) |-> s_bb_release)
    else $error("busy line release wrong");

endmodule

/* design/two_flop_sync.sv */
// Two-stage synchroniser for levels and toggles entering a clock domain
`timescale 1ns/1ps
module two_flop_sync
  import bus_tenure_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] hold;
  } sync_t;

  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s.meta = d;
    next_s.hold = s.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.hold;

endmodule

/* shared/bus_tenure_pkg.sv */
// Shared constants and state encodings for the bus tenure requester
package bus_tenure_pkg;

  // ****************************************************************
  // Link-side state machine
  // ****************************************************************
  typedef enum logic [3:0] {
    L_RST  = 4'h0,
    L_IDLE = 4'h1,
    L_REQ  = 4'h2,
    L_DROP = 4'h3,
    L_ADDR = 4'h4,
    L_DATA = 4'h5,
    L_PARK = 4'h6,
    L_TEND = 4'h7,
    L_TNEG = 4'h8
  } link_state_t;

  // ****************************************************************
  // Bus widths, addresses and codes
  // ****************************************************************
  localparam int          ADDR_W        = 32;
  localparam int          DATA_W        = 32;
  localparam int          TM_W          = 3;
  localparam int          VEC_W         = 8;
  localparam logic [2:0]  TM_NORMAL     = 3'h0;
  localparam logic [7:0]  VEC_SPURIOUS  = 8'h18;
  localparam logic [7:0]  VEC_AUTO_BASE = 8'h18;
  localparam logic [31:0] BOOT_SP_ADDR  = 32'h0000_0000;
  localparam logic [31:0] BOOT_PC_ADDR  = 32'h0000_0004;
  localparam logic [1:0]  BOOT_READS    = 2'h2;
  localparam int          GRANT_WAIT    = 64;

endpackage

/* test/bus_partner.sv */
// Behavioural arbiter and memory slave facing the bus link
`timescale 1ns/1ps
module bus_partner
  import bus_tenure_pkg::*;
(
  // Knobs
  input  wire logic              bus_clk,
  input  wire logic              grant_en,
  input  wire logic              err_k,
  input  wire logic              auto_vector_req_k,
  input  wire logic              inh_k,
  input  wire logic [3:0]        waits_k,
  input  wire logic              reset_input_pin_n,
  // From the device
  input  wire logic              transfer_start_strobe_in_n,
  input  wire logic              bus_request_out_n,
  input  wire logic              tenure_end_toggle_in_n,
  input  wire logic              early_sample_flag,
  input  wire logic              rw_out,
  input  wire logic [TM_W-1:0]   tm_out,
  input  wire logic [ADDR_W-1:0] addr_out,
  input  wire logic [DATA_W-1:0] data_out,
  // To the device
  output logic                   bus_grant_in_n,
  output logic                   transfer_ack_n,
  output logic                   transfer_err_n,
  output logic                   auto_vector_req_n,
  output logic                   burst_inhibit_in_n,
  output logic                   cache_inhibit_in_n,
  output logic [DATA_W-1:0]      data_in,
  // Observations
  output logic [ADDR_W-1:0]      seen_addr,
  output logic [DATA_W-1:0]      seen_wdata,
  output logic [TM_W-1:0]        seen_tm,
  output logic                   seen_rw,
  output logic                   seen_early,
  output int                     drops,
  output int                     te_cyc
);
  int   cnt;
  int   pseed;
  logic req_q;

  initial begin
    cnt = -1;
    pseed = 61210;
    req_q = 1'b1;
    drops = 0;
    te_cyc = 0;
    bus_grant_in_n = 1'b0;
    {transfer_ack_n, transfer_err_n, auto_vector_req_n} = 3'h7;
    {burst_inhibit_in_n, cache_inhibit_in_n} = 2'h3;
    data_in = 32'h0000_0000;
  end

  // Terminations change mid-cycle, away from the sampling edge
  always @(negedge bus_clk) begin
    bus_grant_in_n <= !grant_en;
    {transfer_ack_n, transfer_err_n, auto_vector_req_n} <= 3'h7;
    {burst_inhibit_in_n, cache_inhibit_in_n} <= 2'h3;
    // Idle data bus shows noise so stale values cannot pass
    data_in <= $random(pseed);
    if (!reset_input_pin_n) begin
      cnt <= -1;
    end else if (!transfer_start_strobe_in_n) begin
      seen_addr <= addr_out;
      seen_wdata <= data_out;
      seen_tm <= tm_out;
      seen_rw <= rw_out;
      cnt <= waits_k;
    end else if (cnt == 0) begin
      transfer_err_n <= !err_k;
      transfer_ack_n <= err_k;
      auto_vector_req_n <= !auto_vector_req_k;
      {burst_inhibit_in_n, cache_inhibit_in_n} <= {2{!inh_k}};
      data_in <= (seen_tm != '0) ? (32'h0000_0040 | seen_tm) : (seen_addr ^ 32'h5a5a_0000);
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  always @(posedge bus_clk) begin
    if (!transfer_start_strobe_in_n) seen_early <= 1'b0;
    else if (early_sample_flag) seen_early <= 1'b1;
    req_q <= bus_request_out_n;
    if (bus_request_out_n && !req_q && bus_grant_in_n) drops <= drops + 1;
    if (!tenure_end_toggle_in_n) te_cyc <= te_cyc + 1;
  end
endmodule

/* test/testbench.sv */
// Self-checking bench for the bus tenure requester
`timescale 1ns/1ps
module testbench;
  import bus_tenure_pkg::*;
  logic              ref_clk, bus_clk, rst_n, req_valid, req_write, req_iack, req_more;
  logic              ignore_state_en, req_ready, rsp_valid, rsp_err, rsp_burst_inh;
  logic              rsp_cache_inh, boot_done, early_sample_flag, addr_oe_n, rw_out, data_oe_n;
  logic [ADDR_W-1:0] req_addr, addr_out, seen_addr;
  logic [DATA_W-1:0] req_wdata, rsp_data, boot_sp, boot_pc, data_in, data_out, seen_wdata;
  logic [TM_W-1:0]   req_level, tm_out, seen_tm;
  logic [VEC_W-1:0]  rsp_vector;
  logic              reset_input_pin_n, bus_request_out_n, bus_grant_in_n;
  logic              transfer_start_strobe_out_n, transfer_start_strobe_oe_n;
  logic              bus_busy_line_out_n, bus_busy_line_oe_n;
  logic              tenure_end_toggle_out_n, tenure_end_toggle_oe_n;
  logic              transfer_ack_n, transfer_err_n, auto_vector_req_n;
  logic              burst_inhibit_in_n, cache_inhibit_in_n;
  logic              grant_en, err_k, auto_vector_req_k, inh_k, seen_rw, seen_early, alt_ts_n, alt_te_n;
  logic [3:0]        waits_k;
  int                drops, te_cyc, miscompares, n_checks, rsp_cnt, seed, d;
  // Shared lines are pulled up when nobody drives them; an alternate master joins the start strobe and tenure end lines
  wire transfer_start_strobe_in_n =
    (transfer_start_strobe_oe_n ? 1'b1 : transfer_start_strobe_out_n) & alt_ts_n;
  wire bus_busy_line_in_n = bus_busy_line_oe_n ? 1'b1 : bus_busy_line_out_n;
  wire tenure_end_toggle_in_n =
    (tenure_end_toggle_oe_n ? 1'b1 : tenure_end_toggle_out_n) & alt_te_n;

  bus_tenure_arbitration #(.GRANT_WAIT_CYC(4)) dut (.*);
  bus_partner partner (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    bus_clk = 1'b0;
    #5;
    forever #16 bus_clk = ~bus_clk;
  end
  always @(posedge ref_clk) if (rsp_valid === 1'b1) rsp_cnt <= rsp_cnt + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic issue(input logic wr, ia, input logic [31:0] a, input logic [2:0] lv,
                       input logic [3:0] w, input logic e, av);
    int n;
    @(negedge ref_clk);
    {waits_k, err_k, auto_vector_req_k, inh_k} = {w, e, av, 1'($random(seed))};
    {req_write, req_iack, req_addr, req_level} = {wr, ia, a, lv};
    req_wdata = $random(seed);
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("accepted", 1, n < 4000);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask

  task automatic xfer(input logic wr, ia, input logic [31:0] a, input logic [2:0] lv,
                      input logic [3:0] w, input logic e, av);
    int n;
    logic [31:0] mem;
    mem = a ^ 32'h5a5a_0000;
    issue(wr, ia, a, lv, w, e, av);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("answered", 1, n < 4000);
    chk("rw", !wr, seen_rw);
    if (wr) chk("wdata", req_wdata, seen_wdata);
    chk("early", ignore_state_en, seen_early);
    if (ia) begin
      chk("tm", lv, seen_tm);
      chk("vector", e ? 24 : av ? 24 + lv : 8'h40 | lv, rsp_vector);
    end else begin
      chk("addr", a, seen_addr);
      chk("err", e, rsp_err);
      chk("vector", 0, rsp_vector);
      if (!e && !wr) chk("data", mem, rsp_data);
      if (!e) chk("inhibit", {2{inh_k}}, {rsp_burst_inh, rsp_cache_inh});
    end
  endtask

  task automatic wait_boot();
    int n;
    n = 0;
    while (boot_done !== 1'b1 && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("boot_sp", 32'h5a5a_0000, boot_sp);
    chk("boot_pc", 32'h5a5a_0004, boot_pc);
  endtask

  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  initial begin
    seed = 61210;
    {rst_n, req_valid, req_write, req_iack, req_more, ignore_state_en} = 6'h00;
    {reset_input_pin_n, grant_en, err_k, auto_vector_req_k, inh_k} = 5'h18;
    {req_addr, req_wdata, req_level, waits_k} = '0;
    {miscompares, n_checks, rsp_cnt} = '0;
    {alt_ts_n, alt_te_n} = 2'h3;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    wait_boot();
    for (int l = 1; l < 8; l++) xfer(0, 1, 0, 3'(l), 4'(l % 3), 0, 1);
    xfer(0, 1, 0, 3'h5, 4'h1, 1, 0);
    for (int i = 0; i < 16; i++) begin
      ignore_state_en = i[0];
      req_more = i[1];
      repeat (3) @(negedge bus_clk);
      xfer(i % 3 == 1, i % 5 == 4, {$random(seed)} & 32'h0000_fffc, 3'(1 + i % 7),
           4'({$random(seed)} % 4), i % 6 == 5, 0);
    end
    d = te_cyc;
    grant_en = 1'b0;
    repeat (20) @(negedge bus_clk);
    chk("tenure_end_cycles", 1, te_cyc - d);
    d = drops;
    fork
      xfer(0, 0, 32'h0000_0100, 0, 1, 0, 0);
      begin
        repeat (10) @(negedge bus_clk);
        alt_ts_n = 1'b0;
        @(negedge bus_clk);
        alt_ts_n = 1'b1;
        repeat (20) @(negedge bus_clk);
        grant_en = 1'b1;
        repeat (8) @(negedge bus_clk);
        chk("held_off", 1, addr_oe_n);
        alt_te_n = 1'b0;
        @(negedge bus_clk);
        alt_te_n = 1'b1;
      end
    join
    chk("request_withdrawn", 1, drops > d);
    issue(0, 0, 32'h0000_0200, 0, 15, 0, 0);
    d = rsp_cnt;
    repeat (4) @(negedge bus_clk);
    @(negedge ref_clk);
    reset_input_pin_n = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk("boot_done_low", 0, boot_done);
    reset_input_pin_n = 1'b1;
    wait_boot();
    chk("aborted_silent", d, rsp_cnt);
    end_sim();
  end
endmodule
